/* File: include/dsp_pkg.sv */
// Package of constants and carrier types for the data strobe pin logic
//==========================================================================
package dsp_pkg;

  //==========================================================================
  // Organisation and widths
  localparam int DSP_BYTE_W      = 8;
  localparam int DSP_LANES_X16   = 16;
  localparam int DSP_LOW_REF     = 0;
  localparam int DSP_HIGH_REF    = 8;
  localparam int DSP_BUF_DEPTH   = 2;

  // Bit position of the termination strobe select bit in mode register one
  localparam int DSP_TSEL_BIT    = 11;
  localparam logic [15:0] DSP_MR1_RESET = 16'h0000;

  //==========================================================================
  // Carrier types
  typedef struct packed {
    logic [DSP_LANES_X16-1:0] data;
    logic [1:0]               mask;
  } dsp_beat_t;

  typedef struct packed {
    logic [DSP_LANES_X16-1:0] dq_o;
    logic [DSP_LANES_X16-1:0] dq_oe;
    logic [1:0]               dqs_o;
    logic [1:0]               dqs_oe;
  } dsp_drive_t;

  typedef enum logic [1:0] {
    DSP_IDLE,
    DSP_READ_PRE,
    DSP_READ_BURST
  } dsp_rd_state_t;

endpackage

/* File: verilog/dsp_beat_buf.sv */
// Two-entry valid/ready buffer carrying write beats to the core
`timescale 1ns/100ps
module dsp_beat_buf
  import dsp_pkg::*;
#(
  parameter int DEPTH = DSP_BUF_DEPTH
) (
  input  wire logic      i_sys_clk,
  input  wire logic      i_reset,
  input  wire logic      i_valid,
  output logic           o_ready,
  input  wire dsp_beat_t i_beat,
  output logic           o_valid,
  input  wire logic      i_ready,
  output dsp_beat_t      o_beat
);

  typedef struct packed {
    dsp_beat_t [DEPTH-1:0] mem;
    logic      [1:0]       count;
  } dsp_buf_state_t;

  dsp_buf_state_t st;
  dsp_buf_state_t next_st;
  logic           push;
  logic           pop;

  //==========================================================================
  // Shift-register storage: head always at entry 0
  always_comb begin
    next_st = st;
    push    = i_valid && (st.count != 2'(DEPTH));
    pop     = (st.count != 2'd0) && i_ready;
    if (pop) begin
      for (int k = 0; k < DEPTH-1; k++) begin
        next_st.mem[k] = st.mem[k+1];
      end
    end
    if (push) begin
      next_st.mem[2'(st.count) - (pop ? 2'd1 : 2'd0)] = i_beat;
    end
    next_st.count = st.count + (push ? 2'd1 : 2'd0) - (pop ? 2'd1 : 2'd0);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready = st.count != 2'(DEPTH);
  assign o_valid = st.count != 2'd0;
  assign o_beat  = st.mem[0];

  chk_buf_no_overflow : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    st.count <= 2'(DEPTH))
    else $error("beat buffer count exceeds depth");

endmodule

/* File: verilog/dsp_pin_logic.sv */
// Data lane, strobe, write mask and termination strobe pin logic
`timescale 1ns/100ps
module dsp_pin_logic
  import dsp_pkg::*;
#(
  parameter int  LANES = DSP_LANES_X16,
  parameter bit  IS_X8 = 1'b1
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic              i_reset_pin_n,
  input  wire logic              i_strobe_clk,
  input  wire logic [LANES-1:0]  i_dq,
  input  wire logic [1:0]        i_lower_upper_strobe_n,
  input  wire logic [1:0]        i_write_mask,
  input  wire logic [15:0]       i_mode_register_one,
  input  wire logic              i_mode_register_one_load,
  input  wire logic              i_odt_enable,
  input  wire logic              i_write_leveling,
  input  wire logic              i_rd_valid,
  input  wire logic [LANES-1:0]  i_rd_data,
  output logic                   o_rd_ready,
  output logic [LANES-1:0]       o_dq,
  output logic [LANES-1:0]       o_dq_oe,
  output logic [1:0]             o_lower_upper_strobe,
  output logic [1:0]             o_lower_upper_strobe_n,
  output logic [1:0]             o_strobe_oe,
  output logic [1:0]             o_strobe_odt,
  output logic                   o_termination_strobe_odt,
  output logic                   o_input_pin_odt,
  output logic                   o_wr_valid,
  output logic [LANES-1:0]       o_wr_data,
  output logic                   o_wr_dropped,
  input  wire logic              i_wr_ready
);

  //==========================================================================
  // Link domain: capture write beats on both strobe edges
  // A beat is taken on each rising edge (first half) and falling edge (second).
  typedef struct packed {
    logic [LANES-1:0] data;
    logic [1:0]       mask;
    logic             tgl;
    logic             ok;
  } dsp_link_t;

  dsp_link_t lk_r;
  dsp_link_t next_lk_r;
  dsp_link_t lk_f;
  dsp_link_t next_lk_f;

  // Differential pair: complement must be low at the rising edge, high at the falling
  logic pair_ok;
  assign pair_ok = (i_lower_upper_strobe_n == 2'b00);

  always_comb begin
    next_lk_r    = lk_r;
    next_lk_r.ok = pair_ok;
    if (pair_ok) begin
      next_lk_r.data = i_dq;
      next_lk_r.mask = i_write_mask;
      next_lk_r.tgl  = ~lk_r.tgl;
    end
  end

  always_comb begin
    next_lk_f = lk_f;
    // A stuck complement never passes both edges; held high it passes neither, held low the rising beat is still taken
    if ((i_lower_upper_strobe_n == 2'b11) && lk_r.ok) begin
      next_lk_f.data = i_dq;
      next_lk_f.mask = i_write_mask;
      next_lk_f.tgl  = ~lk_f.tgl;
    end
  end

  // Link clock may stop between bursts, so its toggles are cleared asynchronously
  always_ff @(posedge i_strobe_clk or posedge i_reset) begin
    if (i_reset) begin
      lk_r <= '0;
    end else begin
      lk_r <= next_lk_r;
    end
  end

  always_ff @(negedge i_strobe_clk or posedge i_reset) begin
    if (i_reset) begin
      lk_f <= '0;
    end else begin
      lk_f <= next_lk_f;
    end
  end

  //==========================================================================
  // System domain state
  typedef struct packed {
    logic [1:0]       rst_sync;
    logic [1:0]       tr_sync1;
    logic [1:0]       tr_sync2;
    logic [1:0]       tr_seen;
    logic [15:0]      mr1;
    dsp_rd_state_t    rd_state;
    logic [LANES-1:0] dq;
    logic [LANES-1:0] dq_oe;
    logic [1:0]       dqs;
    logic [1:0]       dqs_oe;
    logic [1:0]       strobe_odt;
    logic             termination_strobe_odt;
    logic             dropped;
  } dsp_state_t;

  dsp_state_t st;
  dsp_state_t next_st;

  // Beat source into the buffer
  logic      in_valid;
  logic      in_ready;
  dsp_beat_t in_beat;
  logic      sel_rise;
  logic      tsel;
  logic      dev_rst;
  dsp_beat_t out_beat;
  logic      out_valid;
  logic      mask_on;

  // Termination strobe mode only on x8 parts
  assign tsel    = IS_X8 && st.mr1[DSP_TSEL_BIT];
  assign dev_rst = ~st.rst_sync[1];
  assign mask_on = ~tsel;

  // Pick the pending edge: rising first, then falling of the same bit
  assign sel_rise = st.tr_sync2[0] != st.tr_seen[0];
  always_comb begin
    in_valid      = sel_rise || (st.tr_sync2[1] != st.tr_seen[1]);
    in_beat.data  = '0;
    in_beat.mask  = '0;
    in_beat.data[LANES-1:0] = sel_rise ? lk_r.data : lk_f.data;
    in_beat.mask  = sel_rise ? lk_r.mask : lk_f.mask;
  end

  always_comb begin
    next_st          = st;
    next_st.rst_sync = {st.rst_sync[0], i_reset_pin_n};
    next_st.tr_sync1 = {lk_f.tgl, lk_r.tgl};
    next_st.tr_sync2 = st.tr_sync1;
    next_st.dropped  = 1'b0;
    if (in_valid && in_ready) begin
      if (sel_rise) begin
        next_st.tr_seen[0] = st.tr_sync2[0];
      end else begin
        next_st.tr_seen[1] = st.tr_sync2[1];
      end
    end
    if (i_mode_register_one_load) begin
      next_st.mr1 = i_mode_register_one;
    end
    // Read path: strobe edge aligned with data change, data driven together
    case (st.rd_state)
      DSP_IDLE: begin
        next_st.dq_oe  = '0;
        next_st.dqs_oe = '0;
        if (i_rd_valid) begin
          next_st.rd_state = DSP_READ_BURST;
          next_st.dq       = i_rd_data;
          next_st.dq_oe    = '1;
          next_st.dqs      = 2'b11;
          next_st.dqs_oe   = 2'b11;
        end
      end
      DSP_READ_BURST: begin
        if (i_rd_valid) begin
          next_st.dq  = i_rd_data;
          next_st.dqs = ~st.dqs;
        end else begin
          next_st.rd_state = DSP_IDLE;
          next_st.dq_oe    = '0;
          next_st.dqs_oe   = '0;
        end
      end
      default: begin
        next_st.rd_state = DSP_IDLE;
      end
    endcase
    // Termination follows the strobe pair while not reading
    next_st.strobe_odt = (i_odt_enable && st.rd_state == DSP_IDLE) ? 2'b11 : 2'b00;
    next_st.termination_strobe_odt   = tsel && i_odt_enable && st.rd_state == DSP_IDLE;
    if (out_valid && i_wr_ready && mask_on && |out_beat.mask) begin
      next_st.dropped = 1'b1;
    end
  end

  // Reset pin is synchronised before use; reset released only while high
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || dev_rst) begin
      st          <= '0;
      st.rst_sync <= next_st.rst_sync & {2{~i_reset}};
      // Keep tracking link toggles so beats seen during reset are not replayed
      st.tr_sync1 <= next_st.tr_sync1;
      st.tr_sync2 <= next_st.tr_sync2;
      st.tr_seen  <= st.tr_sync2;
      st.mr1      <= DSP_MR1_RESET;
      st.rd_state <= DSP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  //==========================================================================
  // Two-entry buffer so a stalled core loses no write beat
  dsp_beat_buf #(
    .DEPTH (DSP_BUF_DEPTH)
  ) u_buf (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset || dev_rst),
    .i_valid   (in_valid),
    .o_ready   (in_ready),
    .i_beat    (in_beat),
    .o_valid   (out_valid),
    .i_ready   (i_wr_ready),
    .o_beat    (out_beat)
  );

  // Masked beats never reach the core unless the termination strobe select bit is set on an x8 part
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_wr_valid <= 1'b0;
      o_wr_data  <= '0;
    end else begin
      o_wr_valid <= out_valid && i_wr_ready && !(mask_on && |out_beat.mask);
      o_wr_data  <= out_beat.data[LANES-1:0];
    end
  end

  // Lane 0 / lane 8 reference during leveling is just the unmodified lane
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rd_ready <= 1'b0;
    end else begin
      o_rd_ready <= !i_write_leveling;
    end
  end

  assign o_dq                   = st.dq;
  assign o_dq_oe                = st.dq_oe;
  assign o_lower_upper_strobe   = st.dqs;
  assign o_lower_upper_strobe_n = ~st.dqs;
  assign o_strobe_oe            = st.dqs_oe;
  assign o_strobe_odt           = st.strobe_odt;
  assign o_termination_strobe_odt = st.termination_strobe_odt;
  assign o_input_pin_odt        = 1'b0;
  assign o_wr_dropped           = st.dropped;

  //==========================================================================
  // Checks
  sequence s_mask_beat;
    out_valid && i_wr_ready && mask_on && |out_beat.mask;
  endsequence

  chk_mask_drops_beat : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_mask_beat |=> !o_wr_valid)
    else $error("masked beat was passed on");
  chk_termination_strobe_x8_only : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_termination_strobe_odt |-> IS_X8 && st.mr1[DSP_TSEL_BIT])
    else $error("termination strobe active on wide part");
  chk_strobe_pair : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_lower_upper_strobe_n == ~o_lower_upper_strobe)
    else $error("strobe pair not complementary");
  chk_read_drive : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_dq_oe[0] |-> o_strobe_oe[0])
    else $error("data driven without strobe");
  chk_termination_strobe_follow : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_termination_strobe_odt |-> o_strobe_odt[0])
    else $error("termination strobe differs from strobe");
  chk_input_no_odt : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !o_input_pin_odt)
    else $error("input pin terminated");
  chk_reset_pin : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !st.rst_sync[1] |=> !o_dq_oe[0])
    else $error("drive during pin reset");
  chk_read_toggle : assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (st.rd_state == DSP_READ_BURST && i_rd_valid && !dev_rst)
      |=> o_lower_upper_strobe != $past(o_lower_upper_strobe))
    else $error("read strobe did not toggle with data");

endmodule

/* File: testbench/dsp_ctrl_model.sv */
// Controller-side model that drives write frames and the reset pin
`timescale 1ns/100ps
module dsp_ctrl_model (
  output logic        o_strobe_clk,
  output logic [1:0]  o_strobe_n,
  output logic [15:0] o_dq,
  output logic [1:0]  o_mask,
  output logic        o_reset_pin_n
);
  //==========================================================================
  // Idle state: strobe pair stands still, reset pin released
  initial begin
    o_strobe_clk  = 1'b0;
    o_strobe_n    = 2'b11;
    o_dq          = 16'h0000;
    o_mask        = 2'b00;
    o_reset_pin_n = 1'b1; // Held high outside deliberate resets
  end

  //==========================================================================
  // One strobe cycle of 32 ns; data changes mid-phase so edges sit centred
  task automatic send(input logic [15:0] d0, input logic [15:0] d1,
                      input logic [1:0] m, input logic single);
    o_dq   = d0;
    o_mask = m;
    #7;
    o_strobe_n   = single ? 2'b11 : 2'b00; // Complement settles first
    #1;
    o_strobe_clk = 1'b1; // Strobe goes with write data
    #8 o_dq = d1; // Centred on both edges
    #7;
    o_strobe_n   = 2'b11;
    #1;
    o_strobe_clk = 1'b0;
    #8;
    // Released lines show the inverse so stale data never looks valid
    o_dq   = ~d1;
    o_mask = 2'b00;
    #400;
  endtask

  // Pin reset pulse, long enough for the two-flop synchroniser
  task automatic pull_reset();
    o_reset_pin_n = 1'b0;
    #400 o_reset_pin_n = 1'b1;
  endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the data strobe pin logic
`timescale 1ns/100ps
module tb;
  import dsp_pkg::*;
  logic        i_sys_clk, i_reset, stb, mr1_load, odt_en, wr_lvl, rd_valid, wr_ready;
  logic        pin_n, termination_strobe_odt, in_odt, rd_ready, wr_valid, wr_drop;
  logic [1:0]  stb_n, mask, st, st_n, st_oe, st_odt;
  logic [15:0] dq, mr1, rd_data, o_dq, dq_oe, wr_data, last_wr;
  int          failures, n_checks, cycles, n_wr, n_drop;
  // Row: select, odt request, mask, single-ended, writes, drops
  typedef struct packed {
    logic sel; logic odt; logic [1:0] m; logic se; logic [1:0] nw; logic [1:0] nd;
  } dsp_row_t;
  dsp_row_t rows [4] = '{'{0,0,2'b00,0,2,0}, '{0,1,2'b01,0,0,2},
                         '{1,1,2'b01,0,2,0}, '{1,0,2'b00,1,0,0}};

  dsp_ctrl_model i_dsp_ctrl_model (.o_strobe_clk(stb), .o_strobe_n(stb_n), .o_dq(dq),
    .o_mask(mask), .o_reset_pin_n(pin_n));

  dsp_pin_logic i_dsp_pin_logic (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_reset_pin_n(pin_n), .i_strobe_clk(stb), .i_dq(dq), .i_lower_upper_strobe_n(stb_n),
    .i_write_mask(mask), .i_mode_register_one(mr1), .i_mode_register_one_load(mr1_load),
    .i_odt_enable(odt_en), .i_write_leveling(wr_lvl), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_rd_ready(rd_ready), .o_dq(o_dq), .o_dq_oe(dq_oe),
    .o_lower_upper_strobe(st), .o_lower_upper_strobe_n(st_n), .o_strobe_oe(st_oe),
    .o_strobe_odt(st_odt), .o_termination_strobe_odt(termination_strobe_odt), .o_input_pin_odt(in_odt),
    .o_wr_valid(wr_valid), .o_wr_data(wr_data), .o_wr_dropped(wr_drop),
    .i_wr_ready(wr_ready));

  //==========================================================================
  // Clock, cycle limit and counting of beats handed to the core
  always #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      n_wr++;
      last_wr = wr_data;
    end
    if (wr_drop === 1'b1) n_drop++;
    if (cycles >= 3000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #5;
  endtask

  task automatic set_mr1(input logic sel);
    mr1 = 16'h0000; // Wide parts would always keep the select bit clear
    mr1[DSP_TSEL_BIT] = sel;
    mr1_load = 1'b1;
    step(1);
    mr1_load = 1'b0;
    step(2);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  //==========================================================================
  // Main sequence: table of write and termination cases, then hand tests
  initial begin
    {i_sys_clk, mr1_load, odt_en, wr_lvl, rd_valid} = '0;
    {failures, n_checks, cycles, n_wr, n_drop} = '0;
    {mr1, rd_data, last_wr} = '0;
    wr_ready = 1'b1;
    i_reset  = 1'b1;
    step(16);
    i_reset = 1'b0;
    step(2); // Pin reset synchroniser fills before the first request
    for (int i = 0; i < 4; i++) begin
      set_mr1(rows[i].sel);
      odt_en = rows[i].odt;
      step(2);
      check("strobe_odt", 16'(rows[i].odt), 16'(st_odt[0]));
      check("termination_strobe_odt", 16'(rows[i].odt & rows[i].sel), 16'(termination_strobe_odt));
      check("input_odt", 16'h0000, 16'(in_odt));
      {n_wr, n_drop} = '0;
      i_dsp_ctrl_model.send(16'h00A5 + 16'(i), 16'h003C + 16'(i), rows[i].m, rows[i].se);
      step(8);
      check("writes", 16'(rows[i].nw), 16'(n_wr));
      check("drops", 16'(rows[i].nd), 16'(n_drop));
      if (rows[i].nw == 2) check("wr_data", 16'h003C + 16'(i), last_wr & 16'h00FF);
    end
    // Back-to-back read beats; strobe starts high and toggles per beat
    odt_en = 1'b0;
    for (int k = 0; k < 3; k++) begin
      rd_data  = 16'hC300 + 16'(k);
      rd_valid = 1'b1;
      step(1);
      check("rd_dq", rd_data, o_dq);
      check("dq_oe", 16'hFFFF, dq_oe);
      check("strobe", (k % 2 == 0) ? 16'h0003 : 16'h0000, 16'(st));
      check("strobe_n", (k % 2 == 0) ? 16'h0000 : 16'h0003, 16'(st_n));
      check("strobe_oe", 16'h0003, 16'(st_oe));
    end
    rd_valid = 1'b0;
    step(1);
    check("dq_oe_off", 16'h0000, dq_oe);
    // Stalled core: both beats of a frame must survive in the buffer
    set_mr1(1'b0);
    wr_ready = 1'b0;
    n_wr = 0;
    i_dsp_ctrl_model.send(16'h0011, 16'h0022, 2'b00, 1'b0);
    step(10);
    wr_ready = 1'b1;
    step(6);
    check("stall_writes", 16'h0002, 16'(n_wr));
    // Write leveling holds off reads
    wr_lvl = 1'b1;
    step(2);
    check("rd_ready_lvl", 16'h0000, 16'(rd_ready));
    wr_lvl = 1'b0;
    step(2);
    check("rd_ready", 16'h0001, 16'(rd_ready));
    // Pin reset clears mode register one, so termination strobe drops
    set_mr1(1'b1);
    odt_en = 1'b1;
    i_dsp_ctrl_model.pull_reset();
    step(3);
    check("termination_strobe_after_pin_reset", 16'h0000, 16'(termination_strobe_odt));
    wrap_up();
  end
endmodule
